// ---- hmp_microport.sv ----
// host microport slave: two strobe conventions, eight locations
// assumes board-strapped mode and position pins, async host strobes
`timescale 1ns/1ps
module hmp_microport import hmp_pkg::*; #(
   parameter int DW = HMP_DW,
   parameter int AW = HMP_AW
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic strobe_direction_mode_i,
   input wire logic chip_sel_n_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [DW-1:0] data_i,
   output logic [DW-1:0] data_o,
   output logic data_oe_o,
   input wire logic data_strobe_n_i,
   input wire logic rd_wr_i,
   output logic transfer_ack_n_o,
   output logic transfer_ack_oe_o,
   input wire logic [HMP_POS_W-1:0] board_position_select_i,
   output logic [2:0] reg_addr_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [DW-1:0] reg_wdata_o,
   input wire logic [DW-1:0] reg_rdata_i,
   output logic selected_o
);
   localparam int SW = 1 + 1 + 1 + 1 + HMP_POS_W;
   localparam int PW = AW + DW;
   logic [SW-1:0] ctl_q;
   logic [PW-1:0] pay_q;
   logic mode_q;
   logic cs_s;
   logic s0_s;
   logic s1_s;
   logic [HMP_POS_W-1:0] pos_s;
   logic [AW-1:0] addr_s;
   logic [DW-1:0] din_s;
   logic rd_req;
   logic wr_req;

   // one sync for all control pins, one for address and data
   hmp_sync #(.W(SW)) u_sync_ctl (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .rst_val_i('0),
      .d_i({strobe_direction_mode_i, ~chip_sel_n_i, ~data_strobe_n_i, ~rd_wr_i,
            board_position_select_i}),
      .q_o(ctl_q)
   );
   hmp_sync #(.W(PW)) u_sync_pay (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .rst_val_i('0),
      .d_i({addr_i, data_i}),
      .q_o(pay_q)
   );
   // chip select, strobe and rd_wr_i pins enter inverted, so a cleared sync reads as idle-inactive
   assign {mode_q, cs_s, s0_s, s1_s, pos_s} = ctl_q;
   assign {addr_s, din_s} = pay_q;

   typedef struct packed {
      hmp_state_t state;
      logic mode;
      logic is_rd;
      logic [DW-1:0] rdata;
      logic [DW-1:0] acr;
      logic [3:0] cnt;
      logic wr;
      logic rd;
   } hmp_st_t;
   hmp_st_t st;
   hmp_st_t next_st;

   logic pos_match;
   assign pos_match = (st.acr[HMP_POS_MSB:HMP_POS_LSB] == pos_s);

   // cs_s is active high here; s0_s/s1_s are active-high strobes
   always_comb begin
      rd_req = 1'b0;
      wr_req = 1'b0;
      if (cs_s) begin
         if (st.mode) begin
            rd_req = s0_s && !s1_s;
            wr_req = s0_s && s1_s;
         end else begin
            rd_req = s0_s;
            wr_req = s1_s;
         end
      end
   end

   always_comb begin
      next_st = st;
      next_st.wr = 1'b0;
      next_st.rd = 1'b0;
      case (st.state)
         HMP_IDLE: begin
            next_st.mode = mode_q;
            if (rd_req || wr_req) begin
               next_st.state = HMP_WAIT;
               next_st.is_rd = rd_req;
               next_st.cnt = '0;
            end
         end
         HMP_WAIT: begin
            // wait lets address/data settle through sync
            next_st.cnt = st.cnt + 4'h1;
            if (st.cnt == 4'(HMP_ACC_CYC - 1)) begin
               next_st.state = HMP_DONE;
               if (st.is_rd) begin
                  next_st.rd = 1'b1;
                  next_st.rdata = (addr_s == HMP_ACR_ADDR) ? st.acr : reg_rdata_i;
               end else begin
                  next_st.wr = pos_match || (addr_s == HMP_ACR_ADDR);
                  if (addr_s == HMP_ACR_ADDR) begin
                     next_st.acr = din_s;
                  end
               end
            end
         end
         HMP_DONE: begin
            if (!rd_req && !wr_req) begin
               next_st.state = HMP_IDLE;
            end
         end
         default: begin
            next_st.state = HMP_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st.state <= HMP_IDLE;
         st.mode <= 1'b0;
         st.is_rd <= 1'b0;
         st.rdata <= '0;
         st.acr <= HMP_ACR_RST;
         st.cnt <= '0;
         st.wr <= 1'b0;
         st.rd <= 1'b0;
      end else if (ce_i) begin
         st <= next_st;
      end
   end

   assign data_o = st.rdata;
   // drive only when selected; uses raw pin so release is immediate
   assign data_oe_o = !chip_sel_n_i && st.is_rd && (st.state == HMP_DONE)
                      && pos_match;
   // mode 1: low ack at completion; mode 0: ready high when done or idle with no request
   assign transfer_ack_n_o = st.mode ? !(st.state == HMP_DONE)
                                     : (st.state != HMP_WAIT) && !(rd_req && st.state == HMP_IDLE)
                                       && !(wr_req && st.state == HMP_IDLE);
   assign transfer_ack_oe_o = !chip_sel_n_i || !st.mode;
   assign reg_addr_o = 3'(addr_s);
   assign reg_wr_o = st.wr;
   assign reg_rd_o = st.rd;
   assign reg_wdata_o = din_s;
   assign selected_o = pos_match;
endmodule : hmp_microport

// ---- hmp_pkg.sv ----
// package for the dual-mode host microport
// assumes a single 250 MHz system clock domain
package hmp_pkg;
   localparam int HMP_DW = 8;
   localparam int HMP_AW = 3;
   localparam int HMP_SYNC_STAGES = 2;
   localparam int HMP_CLK_NS = 4;
   localparam int HMP_ACC_MAX_CYC = 13;
   // internal latency: two sync stages plus decode and data capture
   localparam int HMP_ACC_CYC = 4;
   localparam int HMP_POS_LSB = 2;
   localparam int HMP_POS_MSB = 5;
   localparam int HMP_POS_W = HMP_POS_MSB - HMP_POS_LSB + 1;
   localparam logic [2:0] HMP_ACR_ADDR = 3'h7;
   localparam logic [7:0] HMP_ACR_RST = 8'h00;
   typedef enum logic [1:0] {HMP_IDLE, HMP_WAIT, HMP_DONE} hmp_state_t;
endpackage : hmp_pkg

// ---- hmp_sync.sv ----
// two-flop synchroniser vector
// assumes inputs are asynchronous to sys_clk_i
`timescale 1ns/1ps
module hmp_sync #(
   parameter int W = 1
) (
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   input wire logic [W-1:0] rst_val_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } hmp_sync_st_t;
   hmp_sync_st_t st;
   hmp_sync_st_t next_st;
   always_comb begin
      next_st = st;
      if (ce_i) begin
         next_st.s1 = d_i;
         next_st.s2 = st.s1;
      end
   end
   // reset value only used as constant tie-off by parent
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign q_o = st.s2 ^ rst_val_i;
endmodule : hmp_sync

// ---- hmp_monitor.sv ----
// checker on hmp_microport pins
// assumes bind, one clock, low async reset
`timescale 1ns/1ps
module hmp_monitor(
   input wire logic sys_clk_i,
   input wire logic nrst_i,
   input wire logic strobe_direction_mode_i,
   input wire logic chip_sel_n_i,
   input wire logic [2:0] addr_i,
   input wire logic data_oe_o,
   input wire logic data_strobe_n_i,
   input wire logic rd_wr_i,
   input wire logic transfer_ack_n_o,
   input wire logic [2:0] reg_addr_o,
   input wire logic reg_wr_o,
   input wire logic reg_rd_o,
   input wire logic selected_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_go; $fell(data_strobe_n_i) && !chip_sel_n_i; endsequence
   sequence s_m1; s_go ##0 strobe_direction_mode_i; endsequence
   sequence s_m0; s_go ##0 !strobe_direction_mode_i; endsequence
   // host still selected, else the drivers must already be off
   sequence s_rd;
      s_m1 ##0 rd_wr_i && selected_o ##[1:13] !transfer_ack_n_o && !chip_sel_n_i;
   endsequence
   AST_CS: assert property (chip_sel_n_i |-> !data_oe_o) else $error("bus on");
   AST_POS: assert property (!selected_o |-> !data_oe_o) else $error("bus on");
   AST_ACK: assert property (s_m1 |-> ##[1:13] !transfer_ack_n_o) else $error("ack");
   AST_RDY: assert property (s_m0 |-> ##3 !transfer_ack_n_o) else $error("ready");
   AST_WR: assert property (reg_wr_o |=> !reg_wr_o) else $error("write");
   AST_RD: assert property (reg_rd_o |=> !reg_rd_o) else $error("read");
   AST_ADR: assert property (reg_wr_o || reg_rd_o |-> reg_addr_o == addr_i) else $error("adr");
   AST_DRV: assert property (s_rd |-> data_oe_o) else $error("no drive");
endmodule : hmp_monitor
bind hmp_microport hmp_monitor i_hmp_monitor(.*);

// ---- hmp_host.sv ----
// host model: one byte per access, either strobe convention
// assumes the bench feeds back the device outputs
`timescale 1ns/1ps
module hmp_host(
   input wire logic clk_i,
   input wire logic mode_i,
   input wire logic ack_n_i,
   input wire logic oe_i,
   input wire logic [7:0] rd_i,
   output logic cs_n_o = 1'h1,
   output logic [2:0] a_o = 3'h0,
   output logic [7:0] d_o = 8'h00,
   output logic ds_n_o = 1'h1,
   output logic rw_o = 1'h1
);
   // released address and data lines show the inverse, so stale values never pass
   task automatic acc(input logic rd, input logic [2:0] a, input logic [7:0] d,
      output logic [7:0] q, output logic oe, output int c);
      c = 0;
      @(posedge clk_i);
      #1 {cs_n_o, a_o, d_o, rw_o} = {1'h0, a, d, rd};
      ds_n_o = !(mode_i || rd);
      do begin
         @(negedge clk_i);
         c++;
      end while (c < 20 && !(c > 4 && (ack_n_i ^ mode_i)));
      {q, oe} = {rd_i, oe_i};
      @(posedge clk_i);
      #1 {cs_n_o, a_o, d_o, rw_o, ds_n_o} = {1'h1, ~a, ~d, 2'h3};
      repeat (4) @(posedge clk_i);
   endtask : acc
endmodule : hmp_host

// ---- hmp_microport_tb.sv ----
// bench: host model against hmp_microport, byte store behind it
// assumes the monitor binds itself
`timescale 1ns/1ps
module hmp_microport_tb;
   import hmp_pkg::*;
   logic sys_clk_i = 1'h0, nrst_i = 1'h0, ce_i = 1'h1, strobe_direction_mode_i = 1'h0;
   logic chip_sel_n_i, data_strobe_n_i, rd_wr_i, data_oe_o, transfer_ack_n_o;
   logic transfer_ack_oe_o, reg_wr_o, reg_rd_o, selected_o, oe;
   logic [2:0] addr_i, reg_addr_o;
   logic [3:0] board_position_select_i = 4'h0;
   logic [7:0] data_i, data_o, reg_wdata_o, reg_rdata_i, q, d;
   logic [7:0] mem [8];
   int err_total = 0, comparisons = 0, nwr = 0, tick = 0, c, n;
   hmp_microport i_hmp_microport(.*);
   hmp_host i_hmp_host(.clk_i(sys_clk_i), .mode_i(strobe_direction_mode_i),
      .ack_n_i(transfer_ack_n_o), .oe_i(data_oe_o), .rd_i(data_o), .cs_n_o(chip_sel_n_i),
      .a_o(addr_i), .d_o(data_i), .ds_n_o(data_strobe_n_i), .rw_o(rd_wr_i));
   assign reg_rdata_i = mem[reg_addr_o];
   initial begin
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) begin
      tick++;
      if (reg_wr_o) begin
         nwr++;
         mem[reg_addr_o] <= reg_wdata_o;
      end
      if (tick == 3000) begin
         err_total++;
         give_verdict();
      end
   end
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic t_rw(input logic m);
      @(posedge sys_clk_i);
      #1 strobe_direction_mode_i = m;
      repeat (10) @(posedge sys_clk_i);
      n = nwr;
      for (int a = 0; a < 7; a++) begin
         d = 8'hA5 ^ 8'(a * 17) ^ {m, 7'h00};
         i_hmp_host.acc(1'h0, a[2:0], d, q, oe, c);
         chk(8'(nwr - n), 8'(a + 1));
         i_hmp_host.acc(1'h1, a[2:0], 8'h00, q, oe, c);
         chk(q, d);
         chk({7'h0, oe}, 8'h01);
         chk(8'(c > 13), 8'h00);
      end
      $display("mode %0d done", m);
   endtask : t_rw
   task automatic t_pos;
      @(posedge sys_clk_i);
      #1 board_position_select_i = 4'h5;
      n = nwr;
      i_hmp_host.acc(1'h0, 3'h1, 8'h66, q, oe, c);
      chk(8'(nwr - n), 8'h00);
      i_hmp_host.acc(1'h1, 3'h1, 8'h00, q, oe, c);
      chk({7'h0, oe}, 8'h00);
      i_hmp_host.acc(1'h0, HMP_ACR_ADDR, 8'h14, q, oe, c);
      chk({7'h0, selected_o}, 8'h01);
      $display("position done");
   endtask : t_pos
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict
   initial begin
      repeat (5) @(posedge sys_clk_i);
      #1 nrst_i = 1'h1;
      t_rw(1'h0);
      t_rw(1'h1);
      t_pos;
      give_verdict();
   end
endmodule : hmp_microport_tb
